// file: pisc_core_model.sv
// Far-side model: the processor core that takes requests, and the event sources.
// Assumes the core acknowledges whatever core_req shows at the sampling edge.
`timescale 1ns/10ps
module pisc_core_model (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Request from the block
  input  pisc_pkg::pisc_req_t              core_req,
  // Acknowledge policy set by the bench
  input  wire logic                        ack_en,
  input  wire logic [3:0]                  ack_wait,
  // Drives toward the block
  output logic [pisc_pkg::NUM_SRC-1:0]     src_event,
  output logic                             core_ack
);
  import pisc_pkg::*;
  logic [3:0] wait_q;                      // Cycles the request has waited
  pisc_req_t  served[$];                   // Requests taken, oldest first
  // One-cycle event pulse, launched right after an edge
  task automatic raise(input int i);
    src_event[i] <= 1'b1;
    @(posedge aclk);
    src_event[i] <= 1'b0;
  endtask
  initial
  begin
    src_event = '0;
    core_ack  = 1'b0;
    wait_q    = 4'h0;
  end
  // Log taken requests; acknowledge after a programmable wait
  always @(posedge aclk)
  begin
    if (core_ack && core_req.valid)
      served.push_back(core_req);
    if (!aresetn || core_ack || !core_req.valid || !ack_en)
    begin
      core_ack <= 1'b0;
      wait_q   <= 4'h0;
    end
    else if (wait_q >= ack_wait)
      core_ack <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// file: pisc_pkg.sv
// Shared constants and types for the per-source interrupt control block.
// Assumes a single 100 MHz clock and an AXI4-Lite register path.
package pisc_pkg;

  // Sizes
  localparam int NUM_SRC = 17;                 // Maskable sources held here
  localparam int SRC_W   = 5;                  // Width of a source number
  localparam int ADDR_W  = 18;                 // Byte address width on the bus
  localparam int EV_W    = 2;                  // Number of status events

  // Control byte layout
  localparam int FLAG_BIT = 7;                 // Request pending flag
  localparam int MASK_BIT = 6;                 // Source mask flag
  localparam int MODE_BIT = 5;                 // Servicing mode select
  localparam int CTX_BIT  = 4;                 // Context switch select
  localparam int PRI_HI   = 1;                 // Priority level high bit
  localparam int PRI_LO   = 0;                 // Priority level low bit
  localparam logic [7:0] CTRL_RST = 8'h43;     // Control byte after reset

  // Register indices; byte address is four times the index
  localparam logic [15:0] SRC_IDX [NUM_SRC] = '{
    16'hFFE0, 16'hFFE1, 16'hFFE2, 16'hFFE3, 16'hFFE4, 16'hFFE5, 16'hFFE6,
    16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFEB, 16'hFFEC, 16'hFFED, 16'hFFEE,
    16'hFFEF, 16'hFFF0, 16'hFFF1};
  localparam logic [15:0] STAT_IDX = 16'hFFF4; // Event status, write one to clear
  localparam logic [15:0] IEN_IDX  = 16'hFFF5; // Event interrupt enable

  // Status event bits
  localparam int EV_ACK = 0;                   // A request was acknowledged
  localparam int EV_OVR = 1;                   // Event hit an already pending flag
  localparam logic [EV_W-1:0] STAT_RST = 2'h0; // Status after reset
  localparam logic [EV_W-1:0] IEN_RST  = 2'h0; // Enables after reset

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Servicing route of a presented request, one-hot
  typedef enum logic [2:0] {
    PISC_SVC_VECT  = 3'h1,
    PISC_SVC_CTX   = 3'h2,
    PISC_SVC_MACRO = 3'h4
  } pisc_svc_t;

  // Fields of one source's control byte
  typedef struct packed {
    logic       flag;
    logic       mask;
    logic       macro;
    logic       ctx;
    logic [1:0] level;
  } pisc_ctrl_t;

  // Request presented to the core
  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic [1:0]       level;
    pisc_svc_t        svc;
  } pisc_req_t;

endpackage

// file: pisc_prio_arb.sv
// Priority resolver: lowest level wins, ties go to the lowest source number.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module pisc_prio_arb #(
  parameter int N     = 17,
  parameter int IDX_W = 5
) (
  // Candidates and their levels
  input  wire logic [N-1:0]      cand,
  input  wire logic [1:0]        level [N],
  // Winner
  output logic                   win_valid,
  output logic [IDX_W-1:0]       win_src
);
  // Walk down so that an equal level at a lower number takes over
  always_comb
  begin
    logic [1:0] best;
    best      = 2'h3;
    win_valid = 1'b0;
    win_src   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (cand[i] && (!win_valid || level[i] <= best))
      begin
        win_valid = 1'b1;
        win_src   = IDX_W'(i);
        best      = level[i];
      end
    end
  end
endmodule

// file: pisc_src_cell.sv
// One source's control byte: request flag, mask, mode, context, priority.
// Assumes write strobe, event and acknowledge are single-cycle pulses on aclk.
`timescale 1ns/10ps
module pisc_src_cell (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Software access
  input  wire logic              wr_en,
  input  wire logic [7:0]        wr_data,
  output logic [7:0]             rd_byte,
  // Hardware set and clear
  input  wire logic              hw_event,
  input  wire logic              hw_ack,
  // Current fields
  output pisc_pkg::pisc_ctrl_t   ctrl
);
  import pisc_pkg::*;

  pisc_ctrl_t ctrl_q;                          // Stored fields
  pisc_ctrl_t ctrl_d;                          // Next fields

  // Next value: event beats write, write beats acknowledge
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_en)
    begin
      ctrl_d.mask  = wr_data[MASK_BIT];
      ctrl_d.macro = wr_data[MODE_BIT];
      ctrl_d.ctx   = wr_data[CTX_BIT];
      ctrl_d.level = wr_data[PRI_HI:PRI_LO];
      ctrl_d.flag  = wr_data[FLAG_BIT];
    end
    else if (hw_ack)
      ctrl_d.flag = 1'b0;
    if (hw_event)
      ctrl_d.flag = 1'b1;
  end

  // Storage with reset to the documented byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= pisc_ctrl_t'({CTRL_RST[7:4], CTRL_RST[1:0]});
    else
      ctrl_q <= ctrl_d;
  end

  assign ctrl    = ctrl_q;
  // Bits 3 and 2 always read zero
  assign rd_byte = {ctrl_q.flag, ctrl_q.mask, ctrl_q.macro, ctrl_q.ctx, 2'b00,
                    ctrl_q.level};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_flag_set;
    hw_event |=> ctrl_q.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("request flag not set by event");

  property p_ack_clr;
    (hw_ack && !hw_event && !wr_en && ctrl_q.flag) |=> !ctrl_q.flag;
  endproperty
  a_ack_clr: assert property (p_ack_clr)
    else $error("request flag not cleared by acknowledge");

  property p_sw_write;
    (wr_en && !hw_event) |=> (rd_byte == {$past(wr_data[7:4]), 2'b00, $past(wr_data[1:0])});
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("written control byte not stored");

  property p_set_wins;
    (hw_event && wr_en && !wr_data[FLAG_BIT]) |=> ctrl_q.flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against software clear");

  property p_reset_val;
    disable iff (1'b0) !aresetn |=> (rd_byte == CTRL_RST);
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("control byte wrong after reset");
endmodule

// file: pisc_top.sv
// Per-source interrupt control registers with AXI4-Lite access.
// Assumes events and acknowledge arrive on aclk from on-chip logic.
//
// Overview of operation
// - Source event sets its request flag.
// - Acknowledge clears the acknowledged request flag.
// - Software reads and writes every request flag.
// - Reset clears every request flag.
// - Byte layout: flag, mask, mode, context, priority.
// - Every control register reads 43h after reset.
// - Set flag drives the source's request line.
// - Mode bit chooses vectored or macro service.
// - Context bit chooses vectored or bank switching.
// - Two-bit priority, level zero highest.
// - Masked requests are never acknowledged.
// - Equal levels resolve in fixed source order.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module pisc_top #(
  parameter int N = pisc_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic [pisc_pkg::ADDR_W-1:0]   s_awaddr,
  input  wire logic                          s_awvalid,
  output logic                               s_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_wdata,
  input  wire logic [3:0]                    s_wstrb,
  input  wire logic                          s_wvalid,
  output logic                               s_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_bresp,
  output logic                               s_bvalid,
  input  wire logic                          s_bready,
  // AXI4-Lite read address
  input  wire logic [pisc_pkg::ADDR_W-1:0]   s_araddr,
  input  wire logic                          s_arvalid,
  output logic                               s_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_rdata,
  output logic [1:0]                         s_rresp,
  output logic                               s_rvalid,
  input  wire logic                          s_rready,
  // Source events, one-cycle pulses
  input  wire logic [N-1:0]                  src_event,
  // Core side
  output logic [N-1:0]                       src_irq,
  output pisc_pkg::pisc_req_t                core_req,
  input  wire logic                          core_ack,
  // Event interrupt
  output logic                               irq
);
  import pisc_pkg::*;

  // Write channel state
  logic                 aw_hold_q;             // Address captured, waiting for data
  logic [ADDR_W-1:0]    awaddr_q;              // Captured write address
  logic                 w_hold_q;              // Data captured, waiting for address
  logic [31:0]          wdata_q;               // Captured write data
  logic [3:0]           wstrb_q;               // Captured byte strobes
  logic                 bvalid_q;              // Write response pending
  logic [1:0]           bresp_q;               // Write response code
  // Read channel state
  logic                 rvalid_q;              // Read data pending
  logic [31:0]          rdata_q;               // Read data
  logic [1:0]           rresp_q;               // Read response code
  // Event status and enables
  logic [EV_W-1:0]      stat_q;                // Sticky event bits
  logic [EV_W-1:0]      stat_d;                // Next sticky bits
  logic [EV_W-1:0]      ien_q;                 // Event enables
  // Presented request
  pisc_req_t            req_q;                 // Winner shown to the core
  pisc_req_t            req_d;                 // Next winner

  // Write decode
  wire                  aw_take  = s_awvalid && s_awready;
  wire                  w_take   = s_wvalid && s_wready;
  wire                  have_aw  = aw_hold_q || aw_take;
  wire                  have_w   = w_hold_q || w_take;
  wire                  wr_fire  = have_aw && have_w && !bvalid_q;
  wire [ADDR_W-1:0]     wr_addr  = aw_hold_q ? awaddr_q : s_awaddr;
  wire [31:0]           wr_data  = w_hold_q ? wdata_q : s_wdata;
  wire [3:0]            wr_strb  = w_hold_q ? wstrb_q : s_wstrb;
  wire [15:0]           wr_idx   = wr_addr[ADDR_W-1:2];
  wire                  wr_lane0 = wr_fire && wr_strb[0];
  wire                  wr_stat  = wr_idx == STAT_IDX;
  wire                  wr_ien   = wr_idx == IEN_IDX;
  // Read decode
  wire                  ar_take  = s_arvalid && s_arready;
  wire [15:0]           rd_idx   = s_araddr[ADDR_W-1:2];

  // Per-source wiring
  logic [N-1:0]         src_hit;               // Write address selects source
  logic [N-1:0]         src_rd_hit;            // Read address selects source
  logic [N-1:0]         elig;                  // Pending and unmasked
  logic [N-1:0]         cand;                  // Eligible and not being acknowledged
  logic [N-1:0]         hw_ack;                // Acknowledge per source
  logic [N-1:0]         pend;                  // Request flags
  logic [N-1:0]         masked;                // Mask flags
  logic [7:0]           cell_byte [N];         // Read value per source
  logic [1:0]           cell_lvl  [N];         // Priority per source
  pisc_ctrl_t           cell_ctrl [N];         // Fields per source
  logic                 win_valid;             // Arbiter found a winner
  logic [SRC_W-1:0]     win_src;               // Arbiter's winner

  // Acknowledge counts only for a presented source still unmasked
  // Taken from elig, not cand, so the acknowledge does not loop back on itself
  wire                  ack_take = core_ack && req_q.valid && elig[req_q.src];
  wire                  any_hit  = |src_hit;
  wire                  any_rhit = |src_rd_hit;
  wire                  ovr_ev   = |(src_event & pend);
  wire [EV_W-1:0]       ev_now   = {ovr_ev, ack_take};

  // One control cell per source
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_src
      assign src_hit[i]    = wr_idx == SRC_IDX[i];
      assign src_rd_hit[i] = rd_idx == SRC_IDX[i];
      assign hw_ack[i]     = ack_take && (req_q.src == SRC_W'(i));
      assign pend[i]       = cell_ctrl[i].flag;
      assign masked[i]     = cell_ctrl[i].mask;
      assign cell_lvl[i]   = cell_ctrl[i].level;
      // Only pending, unmasked sources not being acknowledged compete
      assign elig[i]       = pend[i] && !masked[i];
      assign cand[i]       = elig[i] && !hw_ack[i];

      pisc_src_cell u_cell (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_lane0 && src_hit[i]),
        .wr_data  (wr_data[7:0]),
        .rd_byte  (cell_byte[i]),
        .hw_event (src_event[i]),
        .hw_ack   (hw_ack[i]),
        .ctrl     (cell_ctrl[i])
      );
    end
  endgenerate

  // Flag drives the request line directly
  assign src_irq = pend;

  // Priority resolution over the candidates
  pisc_prio_arb #(
    .N     (N),
    .IDX_W (SRC_W)
  ) u_arb (
    .cand      (cand),
    .level     (cell_lvl),
    .win_valid (win_valid),
    .win_src   (win_src)
  );

  // Winner fields and servicing route
  wire pisc_ctrl_t      win_ctrl = cell_ctrl[win_src];
  always_comb
  begin
    req_d.valid = win_valid;
    req_d.src   = win_src;
    req_d.level = win_ctrl.level;
    if (win_ctrl.macro)
      req_d.svc = PISC_SVC_MACRO;
    else if (win_ctrl.ctx)
      req_d.svc = PISC_SVC_CTX;
    else
      req_d.svc = PISC_SVC_VECT;
  end

  // Winner recomputed and registered every cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_q <= '{valid: 1'b0, src: '0, level: 2'h3, svc: PISC_SVC_VECT};
    else
      req_q <= req_d;
  end
  assign core_req = req_q;

  // Sticky events: a new event beats a same-cycle clear
  assign stat_d = (stat_q & ~((wr_lane0 && wr_stat) ? wr_data[EV_W-1:0] : '0)) | ev_now;

  // Status and enable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= STAT_RST;
      ien_q  <= IEN_RST;
    end
    else
    begin
      stat_q <= stat_d;
      if (wr_lane0 && wr_ien)
        ien_q <= wr_data[EV_W-1:0];
    end
  end
  assign irq = |(stat_q & ien_q);

  // Write channel: address and data in either order, answer after both
  assign s_awready = !aw_hold_q && !bvalid_q;
  assign s_wready  = !w_hold_q && !bvalid_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      // Both halves present: complete and answer next cycle
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= (any_hit || wr_stat || wr_ien) ? RESP_OKAY : RESP_SLVERR;
    end
    else
    begin
      // Park whichever half arrived alone
      if (aw_take)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (w_take)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      if (bvalid_q && s_bready)
        bvalid_q <= 1'b0;
    end
  end
  assign s_bvalid = bvalid_q;
  assign s_bresp  = bresp_q;

  // Read mux by register index
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = '0;
    for (int i = 0; i < N; i++)
      if (src_rd_hit[i])
        rd_word = 32'(cell_byte[i]);
    if (rd_idx == STAT_IDX)
      rd_word = 32'(stat_q);
    if (rd_idx == IEN_IDX)
      rd_word = 32'(ien_q);
  end

  // Read channel: answer one cycle after the address is taken
  assign s_arready = !rvalid_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (any_rhit || rd_idx == STAT_IDX || rd_idx == IEN_IDX) ?
                  RESP_OKAY : RESP_SLVERR;
    end
    else if (s_rready)
      rvalid_q <= 1'b0;
  end
  assign s_rvalid = rvalid_q;
  assign s_rdata  = rdata_q;
  assign s_rresp  = rresp_q;

  // Checker helper: some candidate should have beaten the arbiter's pick
  logic arb_beaten;
  always_comb
  begin
    arb_beaten = 1'b0;
    for (int i = 0; i < N; i++)
      if (cand[i] && win_valid &&
          ((cell_lvl[i] < cell_lvl[win_src]) ||
           (cell_lvl[i] == cell_lvl[win_src] && SRC_W'(i) < win_src)))
        arb_beaten = 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_win_macro;
    win_valid && win_ctrl.macro;
  endsequence
  sequence s_win_ctx;
    win_valid && !win_ctrl.macro && win_ctrl.ctx;
  endsequence

  property p_irq_line;
    src_event[0] |=> src_irq[0];
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("source line not raised after event");

  property p_route_macro;
    s_win_macro |=> (core_req.valid && core_req.svc == PISC_SVC_MACRO);
  endproperty
  a_route_macro: assert property (p_route_macro)
    else $error("macro request not routed to macro service");

  property p_route_ctx;
    s_win_ctx |=> (core_req.valid && core_req.svc == PISC_SVC_CTX);
  endproperty
  a_route_ctx: assert property (p_route_ctx)
    else $error("context request not routed to bank switching");

  property p_prio_order;
    !arb_beaten;
  endproperty
  a_prio_order: assert property (p_prio_order)
    else $error("winner is not highest level in source order");

  property p_none_masked;
    (cand == '0) |=> !core_req.valid;
  endproperty
  a_none_masked: assert property (p_none_masked)
    else $error("request presented with no unmasked pending source");

  property p_ack_masked;
    (core_ack && req_q.valid && masked[req_q.src]) |-> (hw_ack == '0);
  endproperty
  a_ack_masked: assert property (p_ack_masked)
    else $error("masked source was acknowledged");

  property p_ack_clears;
    (ack_take && !src_event[req_q.src] && !(wr_lane0 && src_hit[req_q.src])) |=>
      !pend[$past(req_q.src)];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledged flag still set");

  property p_stat_sticky;
    ack_take |=> stat_q[EV_ACK] &&
      (irq == (ien_q[EV_ACK] || (ien_q[EV_OVR] && stat_q[EV_OVR])));
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("acknowledge event lost in status");

  property p_wr_answer;
    (s_awvalid && s_awready && s_wvalid && s_wready) |=> s_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered in one cycle");
endmodule

// file: tb_top.sv
// Bench for the per-source interrupt control block: AXI4-Lite tasks and tests.
// Assumes the core model of pisc_core_model.sv and a 100 MHz clock.
`timescale 1ns/10ps
module tb_top;
  import pisc_pkg::*;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [ADDR_W-1:0]  awaddr = '0, araddr = '0;
  logic [31:0]        wdata = '0, rdata, d;
  logic [3:0]         wstrb = 4'hF;
  logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic               awready, wready, bvalid, arready, rvalid, irq, core_ack;
  logic [1:0]         bresp, rresp, r;
  logic [NUM_SRC-1:0] src_event, src_irq;
  pisc_req_t          core_req;
  logic               ack_en = 1'b0;   // Core takes requests
  logic [3:0]         ack_wait = 4'h0; // Core reaction delay
  int                 errors = 0, checks = 0, k;
  // Device under test and far side
  pisc_top #(.N(NUM_SRC)) pisc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .src_event(src_event), .src_irq(src_irq),
    .core_req(core_req), .core_ack(core_ack), .irq(irq));
  pisc_core_model pisc_core_model_i (.aclk(aclk), .aresetn(aresetn),
    .core_req(core_req), .ack_en(ack_en), .ack_wait(ack_wait),
    .src_event(src_event), .core_ack(core_ack));
  // Free-running clock
  always #5 aclk = ~aclk;
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write one word; holds each channel until taken, bready until bvalid
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (bvalid !== 1'b1 && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end
    rs = bresp;
    bready <= 1'b0;
    // Let an edge pass so the next call does not raise bready in this step
    @(posedge aclk);
    if (n >= 50) chk("write answer", 1, 0);
  endtask
  // Read one word; holds rready until rvalid
  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (rvalid !== 1'b1 && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (arready && arvalid) arvalid <= 1'b0;
    end
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
    // Let an edge pass so the next call does not raise rready in this step
    @(posedge aclk);
    if (n >= 50) chk("read answer", 1, 0);
  endtask
  task automatic wrchk(input logic [15:0] idx, input logic [7:0] v);
    axi_wr(idx, v, r);
    chk("write resp", RESP_OKAY, r);
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    axi_rd(idx, d, r);
    chk("read resp", RESP_OKAY, r);
    chk($sformatf("reg %h", idx), exp, d);
  endtask
  // Wait, bounded, until the core has taken n requests
  task automatic wt(input int n);
    k = 0;
    while (pisc_core_model_i.served.size() < n && k < 100)
    begin
      @(posedge aclk);
      k++;
    end
    chk("served count", n, pisc_core_model_i.served.size());
  endtask
  // Verdict and end of run
  task final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    $display("FAIL watchdog expected finish seen timeout");
    final_report;
  end
  // Priority table: source, control byte, expected route, in expected order
  int        p_src [4] = '{9, 12, 5, 2};
  logic [7:0] p_val [4] = '{8'h91, 8'hA1, 8'h82, 8'hB3};
  pisc_svc_t p_svc [4] = '{PISC_SVC_CTX, PISC_SVC_MACRO, PISC_SVC_VECT, PISC_SVC_MACRO};
  // Test sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("src_irq", 0, src_irq);
    for (int i = 0; i < NUM_SRC; i++) rdchk(SRC_IDX[i], CTRL_RST);
    axi_rd(16'hFFE7, d, r);
    chk("gap resp", RESP_SLVERR, r);
    chk("gap data", 32'h0000_0000, d);
    $display("test reset done");
    wrchk(SRC_IDX[7], 8'hFF);
    rdchk(SRC_IDX[7], 32'h0000_00F3);
    chk("src_irq 7", 1, src_irq[7]);
    wrchk(SRC_IDX[7], CTRL_RST);
    chk("src_irq 7", 0, src_irq[7]);
    $display("test software access done");
    ack_en <= 1'b1;
    pisc_core_model_i.raise(3);
    rdchk(SRC_IDX[3], 32'h0000_00C3);
    chk("masked taken", 0, pisc_core_model_i.served.size());
    pisc_core_model_i.raise(3);
    wrchk(IEN_IDX, 8'h01);
    wrchk(SRC_IDX[3], 8'h81);
    wt(1);
    chk("acked src", 3, pisc_core_model_i.served[0].src);
    rdchk(SRC_IDX[3], 32'h0000_0001);
    rdchk(STAT_IDX, 32'h0000_0003);
    chk("irq on", 1, irq);
    wrchk(IEN_IDX, 8'h00);
    chk("irq masked", 0, irq);
    wrchk(IEN_IDX, 8'h01);
    wrchk(STAT_IDX, 8'h03);
    rdchk(STAT_IDX, 32'h0000_0000);
    chk("irq cleared", 0, irq);
    $display("test acknowledge done");
    ack_en   <= 1'b0;
    ack_wait <= 4'h2;
    pisc_core_model_i.served.delete();
    for (int i = 0; i < 4; i++) wrchk(SRC_IDX[p_src[i]], p_val[i]);
    ack_en <= 1'b1;
    wt(4);
    for (int i = 0; i < 4; i++)
    begin
      chk("order", p_src[i], pisc_core_model_i.served[i].src);
      chk("route", p_svc[i], pisc_core_model_i.served[i].svc);
      chk("level", p_val[i][1:0], pisc_core_model_i.served[i].level);
    end
    $display("test priority done");
    wrchk(SRC_IDX[0], 8'hC3);
    fork
      axi_wr(SRC_IDX[0], CTRL_RST, r);
      pisc_core_model_i.raise(0);
    join
    rdchk(SRC_IDX[0], 32'h0000_00C3);
    $display("test collision done");
    // Reset in mid-run while source 0 still has its flag set
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("src_irq after reset", 0, src_irq);
    rdchk(SRC_IDX[0], CTRL_RST);
    $display("test mid-run reset done");
    final_report;
  end
endmodule
